// *** logic/sfw_pkg.sv ***
package sfw_pkg;
	localparam logic [7:0]  MATCH_BYTE   = 8'h5A;
	localparam logic [7:0]  BAUD_9600    = 8'h28;
	localparam logic [7:0]  BAUD_ERR     = 8'h62;
	localparam logic [7:0]  CMD_FLASH_WR = 8'h30;
	localparam logic [7:0]  CMD_ERR      = 8'h63;
	localparam logic [7:0]  HEX_START    = 8'h3A;
	localparam logic [7:0]  BLANK_LO     = 8'h00;
	localparam logic [7:0]  BLANK_HI     = 8'hFF;
	localparam logic [7:0]  REC_DATA     = 8'h00;
	localparam logic [7:0]  REC_END      = 8'h01;
	localparam logic [15:0] VEC_BASE     = 16'hFFE0;
	localparam logic [15:0] FLASH_BASE   = 16'hC000;
	localparam int          VEC_BYTES    = 32;
	localparam int          FLASH_BYTES  = 16384;
	localparam int          PAGE_BYTES   = 32;
	localparam int          PG_W         = 5;
	localparam logic [1:0]  ERR_REPEAT   = 2'h3;
	localparam logic [1:0]  ADDR_BYTES   = 2'h3;
	localparam int          CLK_KHZ      = 125000;
	localparam int          REC_GAP_MS   = 1;
	localparam int          REC_GAP_CYC  = REC_GAP_MS * CLK_KHZ + 1;
	localparam int          SUM_WAIT_MS  = 100;
	localparam int          TMO_CYC      = 2 * SUM_WAIT_MS * CLK_KHZ;
	localparam int          RETRY_CYC    = 64;
	localparam int          DRST_CYC     = 4;
	localparam logic [2:0]  HX_IDLE      = 3'h0;
	localparam logic [2:0]  HX_LEN       = 3'h1;
	localparam logic [2:0]  HX_AH        = 3'h2;
	localparam logic [2:0]  HX_AL        = 3'h3;
	localparam logic [2:0]  HX_TYPE      = 3'h4;
	localparam logic [2:0]  HX_DATA      = 3'h5;
	localparam logic [2:0]  HX_CSUM      = 3'h6;
endpackage

// *** logic/sfw_link_if.sv ***
`timescale 1ns/100ps
interface sfw_link_if;
	logic [7:0] h2d_data;
	logic       h2d_valid;
	logic       h2d_ready;
	logic       h2d_err;
	logic [7:0] d2h_data;
	logic       d2h_valid;
	logic       dev_rst;
	logic [7:0] baud_code;
	modport dev (
		input  h2d_data, h2d_valid, h2d_err, dev_rst,
		output h2d_ready, d2h_data, d2h_valid, baud_code
	);
	modport host (
		output h2d_data, h2d_valid, h2d_err, dev_rst,
		input  h2d_ready, d2h_data, d2h_valid, baud_code
	);
endinterface

// *** logic/sfw_fifo.sv ***
`timescale 1ns/100ps
module sfw_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready_o  = (cnt_r < (AW+1)'(D));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** logic/sfw_dev.sv ***
// Summary of operation
// - match byte sets initial rate 9600
// - echo match byte; on failure count trial_r, rate stays 9600
// - controller repeats match byte until echo
// - controller sends one of six rate codes
// - echo rate code, switch after echo
// - bad rate code: error three times, halt
// - echo valid flash write command
// - bad command: error three times, halt
// - bytes seven, nine give count address
// - bytes eleven, thirteen give compare address
// - address byte error halts silently
// - compare N password bytes, mismatch halts
// - blank vector area skips password compare
// - controller resets device on an echo or SUM timeout; a stalled stream never times out
// - ignore bytes until record start mark
// - record fields in order, then await start
// - buffer data, program in 32-byte pages
// - controller leaves over 1 ms between records
// - record error halts silently, no SUM
// - after end record send SUM high first
// - controller waits for SUM computation
// - after SUM await next command
`timescale 1ns/100ps
module sfw_dev import sfw_pkg::*; #(
	parameter int         FIFO_D = 16,
	parameter int         SUM_N  = FLASH_BYTES,
	parameter logic [7:0] RATE1  = 8'h18,
	parameter logic [7:0] RATE2  = 8'h20,
	parameter logic [7:0] RATE3  = 8'h38,
	parameter logic [7:0] RATE4  = 8'h40,
	parameter logic [7:0] RATE5  = 8'h48
) (
	input  wire logic    clk_i,
	input  wire logic    rst_i,
	sfw_link_if.dev      lk,
	output logic [15:0]  mem_addr_o,
	input  wire logic [7:0] mem_data_i,
	output logic         fl_we_o,
	output logic [15:0]  fl_addr_o,
	output logic [7:0]   fl_data_o,
	output logic         halted_o
);
	typedef enum logic [11:0] {
		D_MATCH = 12'h001, D_BAUD = 12'h002, D_CMD = 12'h004, D_ADDR = 12'h008,
		D_CNT = 12'h010, D_BLANK = 12'h020, D_PW = 12'h040, D_HEX = 12'h080,
		D_FLUSH = 12'h100, D_SUM = 12'h200, D_TX = 12'h400, D_HALT = 12'h800
	} sfw_dst_t;

	sfw_dst_t      st_r;
	sfw_dst_t      tx_next_r;
	logic          rst;
	logic [7:0]    fd;
	logic          ferr;
	logic          fval;
	logic          pop_ok;
	logic          take;
	logic [15:0]   tx_q_r;
	logic [1:0]    tx_left_r;
	logic          tx_rep_r;
	logic          tx_baud_r;
	logic [7:0]    baud_r;
	logic [7:0]    baud_pend_r;
	logic [7:0]    trial_r;
	logic [1:0]    ab_r;
	logic [15:0]   cnt_addr_r;
	logic [15:0]   pw_addr_r;
	logic [7:0]    n_r;
	logic          rd_pend_r;
	logic [15:0]   idx_r;
	logic          all0_r;
	logic          all1_r;
	logic [15:0]   sum_r;
	logic [2:0]    hx_r;
	logic [7:0]    len_r;
	logic [15:0]   radr_r;
	logic [7:0]    rtype_r;
	logic [7:0]    csum_r;
	logic [7:0]    pbuf_r [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pval_r;
	logic [15-PG_W:0] page_r;
	logic          dirty_r;
	logic          end_pend_r;
	logic          need_flush;
	logic          rate_ok;

	assign rst = rst_i || lk.dev_rst;

	// the fifo lets bursts queue while a page is being programmed
	sfw_fifo #(.W(9), .D(FIFO_D)) sfw_fifo_inst (
		.clk_i       (clk_i),
		.rst_i       (rst),
		.in_data_i   ({lk.h2d_err, lk.h2d_data}),
		.in_valid_i  (lk.h2d_valid),
		.in_ready_o  (lk.h2d_ready),
		.out_data_o  ({ferr, fd}),
		.out_valid_o (fval),
		.out_ready_i (take)
	);

	assign need_flush = (hx_r == HX_DATA) && (rtype_r == REC_DATA) && dirty_r &&
	                    (radr_r[15:PG_W] != page_r);
	assign rate_ok = (fd == BAUD_9600) || (fd == RATE1) || (fd == RATE2) ||
	                 (fd == RATE3) || (fd == RATE4) || (fd == RATE5);

	always_comb begin
		case (st_r)
			D_MATCH, D_BAUD, D_CMD, D_ADDR: pop_ok = 1'b1;
			D_PW:    pop_ok = rd_pend_r;
			D_HEX:   pop_ok = !need_flush;
			default: pop_ok = 1'b0; // halted: queue fills, link stalls
		endcase
	end
	assign take = fval && pop_ok;

	assign lk.d2h_valid = (st_r == D_TX);
	assign lk.d2h_data  = tx_q_r[15:8];
	assign lk.baud_code = baud_r;
	assign halted_o     = (st_r == D_HALT);

	always_ff @(posedge clk_i) begin
		if (rst) begin
			st_r       <= D_MATCH;
			tx_next_r  <= D_MATCH;
			tx_q_r     <= '0;
			tx_left_r  <= '0;
			tx_rep_r   <= 1'b0;
			tx_baud_r  <= 1'b0;
			baud_r     <= BAUD_9600;
			baud_pend_r<= BAUD_9600;
			trial_r    <= '0;
			ab_r       <= '0;
			cnt_addr_r <= '0;
			pw_addr_r  <= '0;
			n_r        <= '0;
			rd_pend_r  <= 1'b0;
			idx_r      <= '0;
			all0_r     <= 1'b1;
			all1_r     <= 1'b1;
			sum_r      <= '0;
			mem_addr_o <= '0;
			end_pend_r <= 1'b0;
		end else begin
			rd_pend_r <= 1'b1;
			case (st_r)
				D_MATCH: if (take) begin
					if (!ferr && fd == MATCH_BYTE) begin
						baud_r    <= BAUD_9600;
						tx_q_r    <= {fd, fd};
						tx_left_r <= 2'h1;
						tx_rep_r  <= 1'b1;
						tx_next_r <= D_BAUD;
						st_r      <= D_TX;
					end else begin
						trial_r <= trial_r + 1'b1;
					end
				end
				D_BAUD: if (take) begin
					tx_q_r   <= rate_ok && !ferr ? {fd, fd} : {BAUD_ERR, BAUD_ERR};
					tx_left_r<= rate_ok && !ferr ? 2'h1 : ERR_REPEAT;
					tx_rep_r <= 1'b1;
					tx_baud_r<= rate_ok && !ferr;
					baud_pend_r <= fd;
					tx_next_r<= rate_ok && !ferr ? D_CMD : D_HALT;
					st_r     <= D_TX;
				end
				D_CMD: if (take) begin
					tx_q_r   <= (fd == CMD_FLASH_WR && !ferr) ? {fd, fd} : {CMD_ERR, CMD_ERR};
					tx_left_r<= (fd == CMD_FLASH_WR && !ferr) ? 2'h1 : ERR_REPEAT;
					tx_rep_r <= 1'b1;
					tx_next_r<= (fd == CMD_FLASH_WR && !ferr) ? D_ADDR : D_HALT;
					ab_r     <= '0;
					st_r     <= D_TX;
				end
				D_ADDR: if (take) begin
					if (ferr) begin
						st_r <= D_HALT;
					end else begin
						case (ab_r)
							2'h0:    cnt_addr_r[15:8] <= fd;
							2'h1:    cnt_addr_r[7:0]  <= fd;
							2'h2:    pw_addr_r[15:8]  <= fd;
							default: pw_addr_r[7:0]   <= fd;
						endcase
						ab_r <= ab_r + 1'b1;
						if (ab_r == ADDR_BYTES) begin
							mem_addr_o <= cnt_addr_r;
							rd_pend_r  <= 1'b0;
							st_r       <= D_CNT;
						end
					end
				end
				D_CNT: if (rd_pend_r) begin
					n_r        <= mem_data_i;
					mem_addr_o <= VEC_BASE;
					rd_pend_r  <= 1'b0;
					idx_r      <= '0;
					all0_r     <= 1'b1;
					all1_r     <= 1'b1;
					st_r       <= D_BLANK;
				end
				D_BLANK: if (rd_pend_r) begin
					all0_r     <= all0_r && (mem_data_i == BLANK_LO);
					all1_r     <= all1_r && (mem_data_i == BLANK_HI);
					mem_addr_o <= mem_addr_o + 1'b1;
					rd_pend_r  <= 1'b0;
					idx_r      <= idx_r + 1'b1;
					if (idx_r == 16'(VEC_BYTES - 1)) begin
						mem_addr_o <= pw_addr_r;
						// blank part skips compare
						if ((all0_r && mem_data_i == BLANK_LO) || (all1_r && mem_data_i == BLANK_HI) ||
						    n_r == '0) begin
							st_r <= D_HEX;
						end else begin
							st_r <= D_PW;
						end
					end
				end
				D_PW: if (take) begin
					if (ferr || fd != mem_data_i) begin
						st_r <= D_HALT;
					end else begin
						mem_addr_o <= mem_addr_o + 1'b1;
						rd_pend_r  <= 1'b0;
						n_r        <= n_r - 1'b1;
						if (n_r == 8'h01) begin
							st_r <= D_HEX;
						end
					end
				end
				D_HEX: begin
					if (need_flush) begin
						idx_r <= '0;
						st_r  <= D_FLUSH;
					end else if (take && ferr) begin
						st_r <= D_HALT;
					end else if (take && hx_r == HX_CSUM && csum_r + fd == '0 && rtype_r == REC_END) begin
						idx_r      <= '0;
						end_pend_r <= 1'b1;
						st_r       <= D_FLUSH;
					end else if (take && hx_r == HX_CSUM && csum_r + fd != '0) begin
						st_r <= D_HALT;
					end
				end
				D_FLUSH: begin
					idx_r <= idx_r + 1'b1;
					if (idx_r == 16'(PAGE_BYTES - 1)) begin
						st_r       <= end_pend_r ? D_SUM : D_HEX;
						end_pend_r <= 1'b0;
						idx_r      <= '0;
						sum_r      <= '0;
						mem_addr_o <= FLASH_BASE;
						rd_pend_r  <= 1'b0;
					end
				end
				D_SUM: if (rd_pend_r) begin
					sum_r      <= sum_r + 16'(mem_data_i);
					mem_addr_o <= mem_addr_o + 1'b1;
					rd_pend_r  <= 1'b0;
					idx_r      <= idx_r + 1'b1;
					if (idx_r == 16'(SUM_N - 1)) begin
						tx_q_r    <= sum_r + 16'(mem_data_i);
						tx_left_r <= 2'h2;
						tx_rep_r  <= 1'b0;
						tx_next_r <= D_CMD;
						st_r      <= D_TX;
					end
				end
				D_TX: begin
					tx_left_r <= tx_left_r - 1'b1;
					if (!tx_rep_r) begin
						tx_q_r <= {tx_q_r[7:0], 8'h00};
					end
					if (tx_left_r == 2'h1) begin
						st_r <= tx_next_r;
						if (tx_baud_r) begin
							baud_r <= baud_pend_r;
						end
						tx_baud_r <= 1'b0;
					end
				end
				D_HALT:  st_r <= D_HALT;
				default: st_r <= D_HALT;
			endcase
		end
	end

	// record field walker; held through a page flush so a record split across pages carries on
	always_ff @(posedge clk_i) begin
		if (rst || (st_r != D_HEX && st_r != D_FLUSH)) begin
			hx_r    <= HX_IDLE;
			csum_r  <= '0;
			len_r   <= '0;
			radr_r  <= '0;
			rtype_r <= '0;
		end else if (take) begin
			csum_r <= csum_r + fd;
			case (hx_r)
				HX_IDLE: begin
					csum_r <= '0;
					if (fd == HEX_START) begin
						hx_r <= HX_LEN;
					end
				end
				HX_LEN:  begin len_r <= fd; hx_r <= HX_AH; end
				HX_AH:   begin radr_r[15:8] <= fd; hx_r <= HX_AL; end
				HX_AL:   begin radr_r[7:0] <= fd; hx_r <= HX_TYPE; end
				HX_TYPE: begin rtype_r <= fd; hx_r <= (len_r == '0) ? HX_CSUM : HX_DATA; end
				HX_DATA: begin
					radr_r <= radr_r + 1'b1;
					len_r  <= len_r - 1'b1;
					if (len_r == 8'h01) begin
						hx_r <= HX_CSUM;
					end
				end
				default: hx_r <= HX_IDLE;
			endcase
		end
	end

	// page buffer and programming strobes
	always_ff @(posedge clk_i) begin
		if (rst) begin
			pval_r    <= '0;
			page_r    <= '0;
			dirty_r   <= 1'b0;
			fl_we_o   <= 1'b0;
			fl_addr_o <= '0;
			fl_data_o <= '0;
		end else begin
			fl_we_o <= 1'b0;
			if (st_r == D_HEX && take && !ferr && hx_r == HX_DATA && rtype_r == REC_DATA) begin
				pbuf_r[radr_r[PG_W-1:0]] <= fd;
				pval_r[radr_r[PG_W-1:0]] <= 1'b1;
				page_r  <= radr_r[15:PG_W];
				dirty_r <= 1'b1;
			end
			if (st_r == D_FLUSH) begin
				fl_we_o   <= pval_r[idx_r[PG_W-1:0]];
				fl_addr_o <= {page_r, idx_r[PG_W-1:0]};
				fl_data_o <= pbuf_r[idx_r[PG_W-1:0]];
				if (idx_r == 16'(PAGE_BYTES - 1)) begin
					pval_r  <= '0;
					dirty_r <= 1'b0;
				end
			end
		end
	end
endmodule

// *** logic/sfw_host.sv ***
`timescale 1ns/100ps
module sfw_host import sfw_pkg::*; #(
	parameter int GAP_CYC = REC_GAP_CYC,
	parameter int TO_CYC  = TMO_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	sfw_link_if.host        lk,
	input  wire logic       start_i,
	input  wire logic [7:0] baud_sel_i,
	input  wire logic [7:0] usr_data_i,
	input  wire logic       usr_valid_i,
	input  wire logic       usr_eor_i,
	input  wire logic       usr_end_i,
	output logic            usr_ready_o,
	output logic [15:0]     sum_o,
	output logic            sum_valid_o,
	output logic            fail_o,
	output logic            busy_o
);
	typedef enum logic [9:0] {
		H_IDLE = 10'h001, H_MATCH = 10'h002, H_BAUD = 10'h004, H_CMD = 10'h008, H_WAIT = 10'h010,
		H_STREAM = 10'h020, H_GAP = 10'h040, H_SUM = 10'h080, H_FAIL = 10'h100, H_RST = 10'h200
	} sfw_hst_t;

	sfw_hst_t   st_r;
	sfw_hst_t   nxt_r;
	logic [7:0] hd_r;
	logic       hv_r;
	logic       eor_r;
	logic       end_r;
	logic [7:0] expect_r;
	logic [31:0] tmr_r;
	logic       got_hi_r;
	logic       sent;

	assign lk.h2d_data  = hd_r;
	assign lk.h2d_valid = hv_r;
	assign lk.h2d_err   = 1'b0;
	assign lk.dev_rst   = (st_r == H_RST);
	assign sent         = hv_r && lk.h2d_ready;
	assign usr_ready_o  = (st_r == H_STREAM) && !hv_r;
	assign busy_o       = (st_r != H_IDLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r        <= H_IDLE;
			nxt_r       <= H_IDLE;
			hd_r        <= '0;
			hv_r        <= 1'b0;
			eor_r       <= 1'b0;
			end_r       <= 1'b0;
			expect_r    <= '0;
			tmr_r       <= '0;
			got_hi_r    <= 1'b0;
			sum_o       <= '0;
			sum_valid_o <= 1'b0;
			fail_o      <= 1'b0;
		end else begin
			sum_valid_o <= 1'b0;
			if (sent) begin
				hv_r <= 1'b0;
			end
			tmr_r <= tmr_r + 1'b1;
			case (st_r)
				H_IDLE: if (start_i) begin
					fail_o <= 1'b0;
					tmr_r  <= '0;
					st_r   <= H_MATCH;
				end
				H_MATCH: begin
					if (!hv_r && tmr_r >= 32'(RETRY_CYC)) begin
						hd_r  <= MATCH_BYTE;
						hv_r  <= 1'b1;
						tmr_r <= '0;
					end
					if (lk.d2h_valid) begin
						st_r <= (lk.d2h_data == MATCH_BYTE) ? H_BAUD : H_FAIL;
					end
				end
				H_BAUD: if (!hv_r) begin
					hd_r     <= baud_sel_i;
					hv_r     <= 1'b1;
					expect_r <= baud_sel_i;
					nxt_r    <= H_CMD;
					tmr_r    <= '0;
					st_r     <= H_WAIT;
				end
				H_CMD: if (!hv_r) begin
					hd_r     <= CMD_FLASH_WR;
					hv_r     <= 1'b1;
					expect_r <= CMD_FLASH_WR;
					nxt_r    <= H_STREAM;
					tmr_r    <= '0;
					st_r     <= H_WAIT;
				end
				H_WAIT: begin
					if (lk.d2h_valid) begin
						st_r <= (lk.d2h_data == expect_r) ? nxt_r : H_FAIL;
					end else if (tmr_r >= 32'(TO_CYC)) begin
						st_r <= H_RST;
					end
				end
				H_STREAM: begin
					if (usr_ready_o && usr_valid_i) begin
						hd_r  <= usr_data_i;
						hv_r  <= 1'b1;
						eor_r <= usr_eor_i;
						end_r <= usr_end_i;
					end
					if (sent && eor_r) begin
						tmr_r    <= '0;
						got_hi_r <= 1'b0;
						st_r     <= end_r ? H_SUM : H_GAP;
					end
				end
				H_GAP: if (tmr_r >= 32'(GAP_CYC)) begin
					st_r <= H_STREAM;
				end
				H_SUM: begin
					if (lk.d2h_valid) begin
						if (!got_hi_r) begin
							sum_o[15:8] <= lk.d2h_data;
							got_hi_r    <= 1'b1;
						end else begin
							sum_o[7:0]  <= lk.d2h_data;
							sum_valid_o <= 1'b1;
							st_r        <= H_IDLE;
						end
					end else if (tmr_r >= 32'(TO_CYC)) begin
						st_r <= H_RST;
					end
				end
				H_FAIL: begin
					fail_o <= 1'b1;
					tmr_r  <= '0;
					st_r   <= H_RST;
				end
				H_RST: begin
					fail_o <= 1'b1;
					hv_r   <= 1'b0;
					if (tmr_r >= 32'(DRST_CYC)) begin
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end
endmodule

// *** tb/sfw_link_monitor.sv ***
`timescale 1ns/100ps
module sfw_link_monitor import sfw_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] h2d_data,
	input  wire logic       h2d_valid,
	input  wire logic       h2d_ready,
	input  wire logic [7:0] d2h_data,
	input  wire logic       d2h_valid,
	input  wire logic       dev_rst,
	input  wire logic [7:0] baud_code
);
	logic       synced_r;
	logic       phase_r;
	logic       last_r;
	logic [7:0] cnt_r;
	logic       take;
	logic       cmd_echo;
	assign take     = h2d_valid && h2d_ready;
	assign cmd_echo = d2h_valid && d2h_data == CMD_FLASH_WR && !phase_r;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || dev_rst);
	always_ff @(posedge clk_i) begin
		if (rst_i || dev_rst) begin
			synced_r <= 1'b0;
		end else if (d2h_valid) begin
			synced_r <= 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		last_r <= d2h_valid;
	end
	// cleared after the second sum byte so a later command echo starts afresh
	always_ff @(posedge clk_i) begin
		if (rst_i || dev_rst) begin
			phase_r <= 1'b0;
		end else if (cmd_echo && synced_r) begin
			phase_r <= 1'b1;
		end else if (phase_r && d2h_valid && last_r) begin
			phase_r <= 1'b0;
		end
	end
	// bytes queued before the echo are missed, so the bound below stays loose
	always_ff @(posedge clk_i) begin
		if (rst_i || dev_rst || cmd_echo) begin
			cnt_r <= 8'h00;
		end else if (phase_r && take && cnt_r != 8'hFF) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	baud_init_a: assert property ($rose(d2h_valid) && d2h_data == MATCH_BYTE |-> baud_code == BAUD_9600)
		else $error("rate not initial at match echo");
	echo_single_a: assert property (d2h_valid && d2h_data == MATCH_BYTE |=> !d2h_valid)
		else $error("match echo longer than one byte");
	match_echo_a: assert property (!synced_r && take && h2d_data == MATCH_BYTE
		|-> ##[2:4] d2h_valid && d2h_data == MATCH_BYTE)
		else $error("match byte not echoed");
	rate_switch_a: assert property ($changed(baud_code) |-> $past(d2h_valid) && $past(d2h_data) == baud_code)
		else $error("rate changed without echo");
	cmd_echo_a: assert property (synced_r && !phase_r && take && h2d_data == CMD_FLASH_WR
		|-> ##[2:40] cmd_echo)
		else $error("command not echoed");
	silent_phase_a: assert property (phase_r && d2h_valid |-> cnt_r >= 8'h0A)
		else $error("reply during address or record bytes");
	sum_pair_a: assert property (phase_r && $rose(d2h_valid) |-> ##1 d2h_valid ##1 !d2h_valid)
		else $error("sum not two bytes");
	fifo_ready_a: assert property ($fell(rst_i) |-> h2d_ready)
		else $error("buffer not ready after reset");
	cover property ($rose(d2h_valid) && d2h_data == MATCH_BYTE);
	cover property ($changed(baud_code));
	cover property (phase_r && $rose(d2h_valid));
endmodule

// *** tb/test_serial_flash_write_protocol.sv ***
`timescale 1ns/100ps
module test_serial_flash_write_protocol import sfw_pkg::*;;
	logic        clk;
	logic        rst;
	logic        start;
	logic [7:0]  baud_sel;
	logic [7:0]  usr_data;
	logic        usr_valid;
	logic        usr_eor;
	logic        usr_end;
	logic        usr_ready;
	logic [15:0] sum;
	logic        sum_valid;
	logic        fail;
	logic [15:0] mem_addr;
	logic        fl_we;
	logic [15:0] fl_addr;
	logic [7:0]  fl_data;
	logic        halted2;
	logic        busy;
	logic        halted;
	logic [7:0]  pw_fill;
	logic [7:0]  mem [0:65535];
	logic [7:0]  rx [$];
	logic [7:0]  rates [6];
	int          fails;
	int          check_count;
	int          cyc;
	sfw_link_if lk();
	sfw_link_if lk2();
	sfw_host #(.GAP_CYC(20), .TO_CYC(5000)) sfw_host_inst (.clk_i(clk), .rst_i(rst), .lk(lk.host),
		.start_i(start), .baud_sel_i(baud_sel), .usr_data_i(usr_data), .usr_valid_i(usr_valid),
		.usr_eor_i(usr_eor), .usr_end_i(usr_end), .usr_ready_o(usr_ready), .sum_o(sum),
		.sum_valid_o(sum_valid), .fail_o(fail), .busy_o(busy));
	sfw_dev #(.SUM_N(8)) sfw_dev_inst (.clk_i(clk), .rst_i(rst), .lk(lk.dev), .mem_addr_o(mem_addr),
		.mem_data_i(mem[mem_addr]), .fl_we_o(fl_we), .fl_addr_o(fl_addr), .fl_data_o(fl_data), .halted_o(halted));
	// fault end: the bench plays the controller so that it can break the order
	sfw_dev sfw_dev_inst_b (.clk_i(clk), .rst_i(rst), .lk(lk2.dev), .mem_addr_o(), .mem_data_i(pw_fill),
		.fl_we_o(), .fl_addr_o(), .fl_data_o(), .halted_o(halted2));
	sfw_link_monitor sfw_link_monitor_inst (.clk_i(clk), .rst_i(rst), .h2d_data(lk.h2d_data),
		.h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data),
		.d2h_valid(lk.d2h_valid), .dev_rst(lk.dev_rst), .baud_code(lk.baud_code));
	always #4 clk = ~clk;
	always @(posedge clk) begin
		if (fl_we === 1'b1) begin
			mem[fl_addr] <= fl_data;
		end
		if (lk2.d2h_valid === 1'b1) begin
			rx.push_back(lk2.d2h_data);
		end
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	task results;
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// released data shows the inverse so a stale byte is never taken by luck
	task send(input logic [7:0] b);
		lk2.h2d_data = b;
		lk2.h2d_valid = 1'b1;
		while (lk2.h2d_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		lk2.h2d_valid = 1'b0;
		lk2.h2d_data = ~b;
		repeat (8) @(posedge clk);
		#1;
	endtask
	task sess(input logic [7:0] rate, input logic [7:0] cmd, input logic ok_rate, input logic ok_cmd);
		logic [7:0] exp [$];
		exp.delete();
		lk2.dev_rst = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		lk2.dev_rst = 1'b0;
		rx.delete();
		send(8'h11);
		chk("reply to non match byte", 16'h0000, 16'(rx.size()));
		send(MATCH_BYTE);
		send(rate);
		exp.push_back(MATCH_BYTE);
		if (ok_rate) begin
			exp.push_back(rate);
			send(cmd);
			if (ok_cmd) begin
				exp.push_back(cmd);
			end else begin
				repeat (3) exp.push_back(CMD_ERR);
			end
		end else begin
			repeat (3) exp.push_back(BAUD_ERR);
		end
		repeat (20) @(posedge clk);
		#1;
		chk("reply count", 16'(exp.size()), 16'(rx.size()));
		foreach (exp[i]) chk("reply byte", 16'(exp[i]), 16'(rx[i]));
		chk("rate code", 16'(ok_rate ? rate : BAUD_9600), 16'(lk2.baud_code));
		chk("uart stopped", 16'(!(ok_rate && ok_cmd)), 16'(halted2));
	endtask
	task flash_write;
		logic [9:0] rec [19];
		int         t;
		// bit 8 marks the last byte of a record, bit 9 the last of the end record
		// four address bytes first, then a stray byte that must be ignored
		rec = '{10'h0C0, 10'h000, 10'h0C0, 10'h010,
			10'h055, 10'h03A, 10'h002, 10'h0C0, 10'h000, 10'h000, 10'h011, 10'h022, 10'h10B,
			10'h03A, 10'h000, 10'h000, 10'h000, 10'h001, 10'h3FF};
		baud_sel = 8'h20;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		foreach (rec[i]) begin
			usr_data = rec[i][7:0];
			usr_eor = rec[i][8];
			usr_end = rec[i][9];
			usr_valid = 1'b1;
			while (usr_ready !== 1'b1) begin
				@(posedge clk);
				#1;
			end
			@(posedge clk);
			#1;
			usr_valid = 1'b0;
		end
		t = 0;
		while (sum_valid !== 1'b1 && t < 4000) begin
			@(posedge clk);
			#1;
			t++;
		end
		chk("sum", 16'h062D, sum);
		chk("flash C000", 16'h0011, 16'(mem[FLASH_BASE]));
		chk("flash C001", 16'h0022, 16'(mem[FLASH_BASE + 16'h0001]));
		chk("host rate", 16'h0020, 16'(lk.baud_code));
		chk("host fail", 16'h0000, 16'(fail));
		chk("host busy", 16'h0000, 16'(busy));
		chk("device halted", 16'h0000, 16'(halted));
	endtask
	// locked part: count and compare bytes all read 03h, so three bytes of 03h unlock it
	task locked(input logic [7:0] last_pw, input logic addr_err);
		lk2.dev_rst = 1'b1;
		pw_fill = 8'h03;
		repeat (4) @(posedge clk);
		#1;
		lk2.dev_rst = 1'b0;
		rx.delete();
		send(MATCH_BYTE);
		send(BAUD_9600);
		send(CMD_FLASH_WR);
		send(8'hC0);
		lk2.h2d_err = addr_err;
		send(8'h00);
		lk2.h2d_err = 1'b0;
		send(8'hC0);
		send(8'h10);
		send(8'h03);
		send(8'h03);
		send(last_pw);
		repeat (100) @(posedge clk);
		#1;
		chk("stopped after password", 16'(addr_err || last_pw != 8'h03), 16'(halted2));
		// one data record whose checksum is wrong
		send(HEX_START);
		send(8'h01);
		send(8'hC0);
		send(8'h00);
		send(REC_DATA);
		send(8'h55);
		send(8'h00);
		repeat (20) @(posedge clk);
		#1;
		chk("stopped after bad record", 16'h0001, 16'(halted2));
		chk("silent reply count", 16'h0003, 16'(rx.size()));
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		start = 1'b0;
		baud_sel = BAUD_9600;
		usr_data = 8'h00;
		usr_valid = 1'b0;
		usr_eor = 1'b0;
		usr_end = 1'b0;
		fails = 0;
		check_count = 0;
		cyc = 0;
		lk2.h2d_data = 8'h00;
		lk2.h2d_valid = 1'b0;
		lk2.h2d_err = 1'b0;
		lk2.dev_rst = 1'b0;
		pw_fill = 8'hFF;
		rates = '{BAUD_9600, 8'h18, 8'h20, 8'h38, 8'h40, 8'h48};
		// blank part: whole map erased, so the password step is skipped
		for (int a = 0; a < 65536; a++) begin
			mem[a] = 8'hFF;
		end
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		flash_write();
		foreach (rates[i]) sess(rates[i], CMD_FLASH_WR, 1'b1, 1'b1);
		sess(8'h55, CMD_FLASH_WR, 1'b0, 1'b0);
		sess(8'h20, 8'h77, 1'b1, 1'b0);
		locked(8'h03, 1'b0);
		locked(8'h04, 1'b0);
		locked(8'h03, 1'b1);
		results();
	end
endmodule
